// [lcb_unit.sv]
// Legacy compatibility bus unit: registers, FPU error, bit 20 mask, VGA SMI, region attributes
//
// How it works
// - Native numeric error bit set keeps the FPU error interrupt inactive.
// - With that bit clear, error summary flag rising raises the interrupt.
// - The acknowledge drops the interrupt and tells the FPU to ignore errors.
// - Clearing the summary flag ends ignoring; the interrupt may fire again.
// - Mask bit set forces address bit 20 low except in SMI mode.
// - I/O cycles in 3B0h, 3C0h, 3D0h ranges may each raise an SMI.
// - At reset values no VGA range access raises an SMI.
// - Nineteen regions exist; three cover A0000h, B0000h and B8000h areas.
// - Each graphics region has an enable routing its accesses to graphics.
// - C0000h to FFFFFh splits into sixteen independent 16 KB regions.
// - Every region has read, write, cache and PCI master bits, freely combined.
// - A 100h-byte window at 8000h decodes; only four words are defined.
// - Top-of-memory register resets to 3FFFFFFFh, its largest value.
// - First map register resets to zero and holds A/B, SMI, PCI, mask controls.
// - Second map register holds eight fields for regions C0h through DCh.
// - Third map register holds fields for regions E0h through FCh.
// - A graphics-routed region is never cacheable; its cache bit is ignored.
// - Bit 22 of the first map register lets PCI slave reach internal registers.
// - Top field bits 27:17; code 000h means 0001FFFFh, 7FFh means 0FFFFFFFh.
`timescale 1ns/1ps
module lcb_unit
  import lcb_pkg::*;
(
  input  wire logic                REF_CLK,
  input  wire logic                RST_B,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [APB_AW-1:0]   PADDR,
  input  wire logic [31:0]         PWDATA,
  input  wire logic [3:0]          PSTRB,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                NATIVE_NUMERIC_ERROR_BIT,
  input  wire logic                ERROR_SUMMARY_FLAG,
  output logic                     FPU_ERROR_INTERRUPT,
  output logic                     IGNORE_NUMERIC_FAULT,
  input  wire lcb_io_req_t         IO_REQ,
  output logic                     SMI_REQ,
  input  wire lcb_mem_req_t        MEM_REQ,
  output lcb_mem_rsp_t             MEM_RSP,
  output logic                     PCI_INTERNAL_ACCESS_ENABLE,
  output logic      [31:0]         DRAM_TOP
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [TOP_HI:TOP_LO] top_field;
  logic [31:0]          xmap_ab;
  logic [31:0]          xmap_cd;
  logic [31:0]          xmap_ef;
  lcb_apb_st_t          apb_st;
  lcb_apb_st_t          next_apb_st;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire        apb_access = PSEL & PENABLE;
  wire        in_window  = (PADDR >= WIN_BASE) & (PADDR < (WIN_BASE + WIN_SIZE));
  wire        word_align = (PADDR[1:0] == 2'b00);
  wire        sel_top    = in_window & (PADDR == OFF_DRAM_TOP);
  wire        sel_ab     = in_window & (PADDR == OFF_XMAP_AB);
  wire        sel_cd     = in_window & (PADDR == OFF_XMAP_CD);
  wire        sel_ef     = in_window & (PADDR == OFF_XMAP_EF);
  wire        bad_access = ~in_window | ~word_align;
  wire        commit     = apb_access & (apb_st == ST_ACK) & ~bad_access & PWRITE;
  wire [31:0] strb_mask  = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  // Top of memory: low bits always one, upper reserved bits zero
  wire [31:0] top_word   = {2'b00, top_field, TOP_LOW_ONES};

  // Undefined words inside the window read as zero
  wire [31:0] read_word  = sel_top ? top_word :
                           sel_ab  ? xmap_ab  :
                           sel_cd  ? xmap_cd  :
                           sel_ef  ? xmap_ef  : 32'h00000000;

  wire [31:0] wdata_top  = (top_word & ~strb_mask) | (PWDATA & strb_mask);
  wire [31:0] wdata_ab   = ((xmap_ab & ~strb_mask) | (PWDATA & strb_mask)) & XMAP_AB_WMASK;
  wire [31:0] wdata_cd   = (xmap_cd & ~strb_mask) | (PWDATA & strb_mask);
  wire [31:0] wdata_ef   = (xmap_ef & ~strb_mask) | (PWDATA & strb_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer held in flip-flops

  always_comb begin
    next_apb_st = apb_st;
    case (apb_st)
      ST_IDLE: begin
        if (apb_access) begin
          next_apb_st = ST_ACK;
        end
      end
      ST_ACK: begin
        next_apb_st = ST_IDLE;
      end
      ST_HOLD: begin
        next_apb_st = ST_IDLE;
      end
      default: begin
        next_apb_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      apb_st <= ST_IDLE;
    end else begin
      apb_st <= next_apb_st;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= (apb_st == ST_IDLE) & apb_access;
      PSLVERR <= (apb_st == ST_IDLE) & apb_access & bad_access;
      if ((apb_st == ST_IDLE) & apb_access) begin
        PRDATA <= (PWRITE | bad_access) ? 32'h00000000 : read_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes land at the edge that completes the transfer

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      top_field <= RST_DRAM_TOP[TOP_HI:TOP_LO];
      xmap_ab   <= RST_XMAP_AB;
      xmap_cd   <= RST_XMAP_CD;
      xmap_ef   <= RST_XMAP_EF;
    end else if (commit) begin
      if (sel_top) begin
        top_field <= wdata_top[TOP_HI:TOP_LO];
      end
      if (sel_ab) begin
        xmap_ab <= wdata_ab;
      end
      if (sel_cd) begin
        xmap_cd <= wdata_cd;
      end
      if (sel_ef) begin
        xmap_ef <= wdata_ef;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Static control outputs

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PCI_INTERNAL_ACCESS_ENABLE <= 1'b0;
      DRAM_TOP                   <= RST_DRAM_TOP;
    end else begin
      PCI_INTERNAL_ACCESS_ENABLE <= xmap_ab[B_PCI_INTERNAL_ACCESS_ENABLE];
      DRAM_TOP                   <= top_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FPU error reporting

  logic es_prev;
  logic err_pend;

  wire io_ack_port = (IO_REQ.addr == IO_FPU_ACK0) | (IO_REQ.addr == IO_FPU_ACK1);
  wire fpu_ack     = IO_REQ.valid & IO_REQ.write & IO_REQ.byte_op & io_ack_port;
  wire es_rise     = ERROR_SUMMARY_FLAG & ~es_prev;
  wire err_event   = es_rise & ~IGNORE_NUMERIC_FAULT & ~NATIVE_NUMERIC_ERROR_BIT;
  wire next_ignore = fpu_ack | (IGNORE_NUMERIC_FAULT & ERROR_SUMMARY_FLAG);
  wire next_pend   = err_event | (err_pend & ~fpu_ack);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      es_prev              <= 1'b0;
      err_pend             <= 1'b0;
      IGNORE_NUMERIC_FAULT <= 1'b0;
      FPU_ERROR_INTERRUPT  <= 1'b0;
    end else begin
      es_prev              <= ERROR_SUMMARY_FLAG;
      err_pend             <= next_pend;
      IGNORE_NUMERIC_FAULT <= next_ignore;
      FPU_ERROR_INTERRUPT  <= next_pend & ~NATIVE_NUMERIC_ERROR_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // VGA I/O SMI generation

  logic hit_3b;
  logic hit_3c;
  logic hit_3d;

  // Enables are zero after reset, so no SMI until software sets them
  lcb_io_range #(.BASE(IO_VGA_3B)) u_range_3b (
    .io_valid (IO_REQ.valid),
    .io_addr  (IO_REQ.addr),
    .enable   (xmap_ab[B_SMI_3B]),
    .hit      (hit_3b)
  );

  lcb_io_range #(.BASE(IO_VGA_3C)) u_range_3c (
    .io_valid (IO_REQ.valid),
    .io_addr  (IO_REQ.addr),
    .enable   (xmap_ab[B_SMI_3C]),
    .hit      (hit_3c)
  );

  lcb_io_range #(.BASE(IO_VGA_3D)) u_range_3d (
    .io_valid (IO_REQ.valid),
    .io_addr  (IO_REQ.addr),
    .enable   (xmap_ab[B_SMI_3D]),
    .hit      (hit_3d)
  );

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SMI_REQ <= 1'b0;
    end else begin
      SMI_REQ <= hit_3b | hit_3c | hit_3d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory access path: bit 20 mask, then region attributes

  logic                           reg_hit;
  logic [4:0]                     reg_idx;
  logic [NUM_REGIONS-1:0][3:0]    fields;

  wire        a20_force  = xmap_ab[B_LEGACY_ADDR_WRAP_PIN] & ~MEM_REQ.smi;
  wire [31:0] eff_addr   = {MEM_REQ.addr[31:A20_BIT+1],
                            MEM_REQ.addr[A20_BIT] & ~a20_force,
                            MEM_REQ.addr[A20_BIT-1:0]};

  // Region order: A, B0, B8, then C0h through FCh
  assign fields = {xmap_ef, xmap_cd,
                   xmap_ab[F_B8_LO+3:F_B8_LO],
                   xmap_ab[F_B0_LO+3:F_B0_LO],
                   xmap_ab[F_A_LO+3:F_A_LO]};

  lcb_region_decode u_region (
    .addr (eff_addr),
    .hit  (reg_hit),
    .idx  (reg_idx)
  );

  wire [3:0] sel_field = reg_hit ? fields[reg_idx] : 4'h0;
  wire       gfx_route = reg_hit & (((reg_idx == REG_IDX_A)  & xmap_ab[B_GEA])  |
                                    ((reg_idx == REG_IDX_B0) & xmap_ab[B_GEB0]) |
                                    ((reg_idx == REG_IDX_B8) & xmap_ab[B_GEB8]));
  wire       above_top = (eff_addr > top_word);

  // Every access is registered with the controls of its own decode cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_RSP <= '0;
    end else begin
      MEM_RSP.valid     <= MEM_REQ.valid;
      MEM_RSP.write     <= MEM_REQ.write;
      MEM_RSP.addr      <= eff_addr;
      MEM_RSP.legacy    <= reg_hit;
      MEM_RSP.rd_en     <= sel_field[RC_READ];
      MEM_RSP.wr_en     <= sel_field[RC_WRITE];
      MEM_RSP.cache_en  <= sel_field[RC_CACHE] & ~gfx_route;
      MEM_RSP.pci_en    <= sel_field[RC_PCI];
      MEM_RSP.to_gfx    <= gfx_route;
      MEM_RSP.above_top <= above_top;
    end
  end

endmodule

// [lcb_pkg.sv]
// Constants, field layouts and carrier types of the legacy compatibility bus unit
package lcb_pkg;

  // Register window and offsets (byte addresses)
  localparam int unsigned    APB_AW          = 16;
  localparam logic [15:0]    WIN_BASE        = 16'h8000;
  localparam logic [15:0]    WIN_SIZE        = 16'h0100;
  localparam logic [15:0]    OFF_DRAM_TOP    = 16'h8000;
  localparam logic [15:0]    OFF_XMAP_AB     = 16'h8004;
  localparam logic [15:0]    OFF_XMAP_CD     = 16'h8008;
  localparam logic [15:0]    OFF_XMAP_EF     = 16'h800C;

  // Reset values
  localparam logic [31:0]    RST_DRAM_TOP    = 32'h3FFFFFFF;
  localparam logic [31:0]    RST_XMAP_AB     = 32'h00000000;
  localparam logic [31:0]    RST_XMAP_CD     = 32'h00000000;
  localparam logic [31:0]    RST_XMAP_EF     = 32'h00000000;

  // Top of memory: stored bits 29:17, code field 27:17, low bits read as one
  localparam int unsigned    TOP_HI          = 29;
  localparam int unsigned    TOP_LO          = 17;
  localparam int unsigned    TOP_CODE_HI     = 27;
  localparam logic [16:0]    TOP_LOW_ONES    = 17'h1FFFF;

  // Map register one fields
  localparam int unsigned    F_A_LO          = 0;
  localparam int unsigned    B_GEA           = 4;
  localparam int unsigned    B_SMI_3B        = 13;
  localparam int unsigned    B_SMI_3C        = 14;
  localparam int unsigned    B_SMI_3D        = 15;
  localparam int unsigned    F_B0_LO         = 16;
  localparam int unsigned    B_GEB0          = 20;
  localparam int unsigned    B_LEGACY_ADDR_WRAP_PIN          = 21;
  localparam int unsigned    B_PCI_INTERNAL_ACCESS_ENABLE          = 22;
  localparam int unsigned    F_B8_LO         = 24;
  localparam int unsigned    B_GEB8          = 28;
  localparam logic [31:0]    XMAP_AB_WMASK   = 32'h1F7FE01F;

  // Region control field bits
  localparam int unsigned    RC_READ         = 0;
  localparam int unsigned    RC_WRITE        = 1;
  localparam int unsigned    RC_CACHE        = 2;
  localparam int unsigned    RC_PCI          = 3;
  localparam int unsigned    NUM_REGIONS     = 19;
  localparam logic [4:0]     REG_IDX_A       = 5'h00;
  localparam logic [4:0]     REG_IDX_B0      = 5'h01;
  localparam logic [4:0]     REG_IDX_B8      = 5'h02;
  localparam logic [4:0]     REG_IDX_C0      = 5'h03;

  // I/O decode
  localparam logic [15:0]    IO_VGA_3B       = 16'h03B0;
  localparam logic [15:0]    IO_VGA_3C       = 16'h03C0;
  localparam logic [15:0]    IO_VGA_3D       = 16'h03D0;
  localparam logic [15:0]    IO_FPU_ACK0     = 16'h00F0;
  localparam logic [15:0]    IO_FPU_ACK1     = 16'h00F1;
  localparam int unsigned    A20_BIT         = 20;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        smi;
    logic [31:0] addr;
  } lcb_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic        legacy;
    logic        rd_en;
    logic        wr_en;
    logic        cache_en;
    logic        pci_en;
    logic        to_gfx;
    logic        above_top;
  } lcb_mem_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_op;
    logic [15:0] addr;
  } lcb_io_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_HOLD = 3'b100
  } lcb_apb_st_t;

endpackage

// [lcb_io_range.sv]
// Matches one 16-byte I/O range against an I/O cycle
`timescale 1ns/1ps
module lcb_io_range
  import lcb_pkg::*;
#(
  parameter logic [15:0] BASE = 16'h0000
) (
  input  wire logic        io_valid,
  input  wire logic [15:0] io_addr,
  input  wire logic        enable,
  output logic             hit
);

  wire base_match = (io_addr[15:4] == BASE[15:4]);

  assign hit = io_valid & enable & base_match;

endmodule

// [lcb_region_decode.sv]
// Maps a physical address to one of the nineteen regions between 640 KB and 1 MB
`timescale 1ns/1ps
module lcb_region_decode
  import lcb_pkg::*;
(
  input  wire logic [31:0] addr,
  output logic             hit,
  output logic [4:0]       idx
);

  wire below_1m = (addr[31:20] == 12'h000);
  wire in_a     = below_1m & (addr[19:16] == 4'hA);
  wire in_b0    = below_1m & (addr[19:15] == 5'b10110);
  wire in_b8    = below_1m & (addr[19:15] == 5'b10111);
  // Sixteen 16 KB regions from C0000h up
  wire in_cf    = below_1m & (addr[19:18] == 2'b11);
  wire [4:0] cf_idx = REG_IDX_C0 + {1'b0, addr[17:14]};

  assign hit = in_a | in_b0 | in_b8 | in_cf;
  assign idx = in_a  ? REG_IDX_A  :
               in_b0 ? REG_IDX_B0 :
               in_b8 ? REG_IDX_B8 :
               in_cf ? cf_idx     : 5'h00;

endmodule

// [lcb_unit_assertions.sv]
// Port-level checks of the legacy compatibility bus unit
`timescale 1ns/1ps
module lcb_unit_sva
  import lcb_pkg::*;
(
  input wire logic         REF_CLK,
  input wire logic         RST_B,
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PWRITE,
  input wire logic [15:0]  PADDR,
  input wire logic [31:0]  PWDATA,
  input wire logic [3:0]   PSTRB,
  input wire logic         PREADY,
  input wire logic         PSLVERR,
  input wire logic         NATIVE_NUMERIC_ERROR_BIT,
  input wire logic         ERROR_SUMMARY_FLAG,
  input wire logic         FPU_ERROR_INTERRUPT,
  input wire logic         IGNORE_NUMERIC_FAULT,
  input wire lcb_io_req_t  IO_REQ,
  input wire logic         SMI_REQ,
  input wire lcb_mem_req_t MEM_REQ,
  input wire lcb_mem_rsp_t MEM_RSP,
  input wire logic         PCI_INTERNAL_ACCESS_ENABLE
);
  ////////////////////////////////////////
  // Shadow of the first map register
  logic [31:0] map_ab;
  wire [31:0] lane = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [31:0] next_map_ab = ((PWDATA & lane) | (map_ab & ~lane)) & XMAP_AB_WMASK;
  wire wr_ab = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == OFF_XMAP_AB;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) map_ab <= RST_XMAP_AB;
    else if (wr_ab) map_ab <= next_map_ab;
  end
  wire ack = IO_REQ.valid && IO_REQ.write && IO_REQ.byte_op
             && (IO_REQ.addr == IO_FPU_ACK0 || IO_REQ.addr == IO_FPU_ACK1);
  wire [11:0] blk = IO_REQ.addr[15:4];
  wire smi_hit = IO_REQ.valid && (blk == 12'h03B && map_ab[B_SMI_3B]
                 || blk == 12'h03C && map_ab[B_SMI_3C] || blk == 12'h03D && map_ab[B_SMI_3D]);
  wire bad = PADDR[1:0] != 2'b00 || PADDR[15:8] != 8'h80;
  wire a20 = MEM_REQ.addr[20] && !(map_ab[B_LEGACY_ADDR_WRAP_PIN] && !MEM_REQ.smi);
  wire [31:0] eff = {MEM_REQ.addr[31:21], a20, MEM_REQ.addr[19:0]};
  wire gfx_b8 = MEM_REQ.valid && eff[31:15] == 17'h00017 && map_ab[B_GEB8];
  ////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  chk_ne_blocks_irq: assert property (NATIVE_NUMERIC_ERROR_BIT |=> !FPU_ERROR_INTERRUPT)
    else $error("fpu interrupt high in native error mode");
  chk_es_raises_irq: assert property ($rose(ERROR_SUMMARY_FLAG) && !NATIVE_NUMERIC_ERROR_BIT
    && !IGNORE_NUMERIC_FAULT |=> FPU_ERROR_INTERRUPT) else $error("fpu interrupt not raised");
  chk_ack_drops_irq: assert property (ack && ERROR_SUMMARY_FLAG && !$rose(ERROR_SUMMARY_FLAG)
    |=> !FPU_ERROR_INTERRUPT && IGNORE_NUMERIC_FAULT) else $error("acknowledge not honoured");
  chk_es_resumes: assert property ($fell(ERROR_SUMMARY_FLAG) && !ack |=> !IGNORE_NUMERIC_FAULT)
    else $error("fpu still ignoring after flag cleared");
  chk_a20_address: assert property (MEM_REQ.valid |=> MEM_RSP.valid && MEM_RSP.addr == $past(eff))
    else $error("memory address bit 20 wrong");
  chk_smi_match: assert property (1'b1 |=> SMI_REQ == $past(smi_hit))
    else $error("smi request wrong");
  chk_apb_ready: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready one cycle into access");
  chk_window_error: assert property (PSEL && PENABLE && PREADY |-> PSLVERR == bad)
    else $error("slave error wrong for address");
  chk_pci_enable: assert property ($stable(map_ab) |-> PCI_INTERNAL_ACCESS_ENABLE == map_ab[B_PCI_INTERNAL_ACCESS_ENABLE])
    else $error("pci access enable differs from register");
  chk_gfx_uncached: assert property (gfx_b8 |=> MEM_RSP.to_gfx && !MEM_RSP.cache_en)
    else $error("graphics region routing or caching wrong");
  cover property (ack && ERROR_SUMMARY_FLAG);
  cover property (SMI_REQ);
  cover property (gfx_b8);
endmodule

bind lcb_unit lcb_unit_sva lcb_unit_sva_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .NATIVE_NUMERIC_ERROR_BIT(NATIVE_NUMERIC_ERROR_BIT),
  .ERROR_SUMMARY_FLAG(ERROR_SUMMARY_FLAG), .FPU_ERROR_INTERRUPT(FPU_ERROR_INTERRUPT),
  .IGNORE_NUMERIC_FAULT(IGNORE_NUMERIC_FAULT), .IO_REQ(IO_REQ), .SMI_REQ(SMI_REQ),
  .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP), .PCI_INTERNAL_ACCESS_ENABLE(PCI_INTERNAL_ACCESS_ENABLE));

// [lcb_far_side.sv]
// Model of the core, FPU and bus units facing the unit
`timescale 1ns/1ps
module lcb_far_side
  import lcb_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         smi_req,
  input  wire lcb_mem_rsp_t mem_rsp,
  output lcb_io_req_t       io_req,
  output lcb_mem_req_t      mem_req,
  output logic              ne,
  output logic              es
);
  initial begin
    io_req = '0;
    mem_req = '0;
    ne = 1'b0;
    es = 1'b0;
  end
  // Byte-wide I/O cycle; returns the smi pulse that follows it (VGA range traps)
  task automatic io(input logic [15:0] a, input logic w, output logic s);
    @(posedge ref_clk);
    io_req <= {1'b1, w, 1'b1, a};
    @(posedge ref_clk);
    io_req <= {1'b0, 1'b0, 1'b0, ~a};
    #1;
    s = smi_req;
  endtask
  task automatic mem(input logic [31:0] a, input logic smi, output lcb_mem_rsp_t r);
    @(posedge ref_clk);
    mem_req <= {1'b1, 1'b0, smi, a};
    @(posedge ref_clk);
    mem_req <= {1'b0, 1'b0, 1'b0, ~a};
    #1;
    r = mem_rsp;
  endtask
  task automatic fpu(input logic n, input logic e);
    @(posedge ref_clk);
    ne <= n;
    es <= e;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// [lcb_unit_tb.sv]
// Self-checking bench of the legacy compatibility bus unit
`timescale 1ns/1ps
module lcb_unit_tb;
  import lcb_pkg::*;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, ign, smi, pci, ne, es, s;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, dram_top;
  lcb_io_req_t io_req;
  lcb_mem_req_t mem_req;
  lcb_mem_rsp_t mem_rsp, r;
  int err_count, n_checks;
  int cycles = 0;
  localparam logic [31:0] MAP_AB = 32'h1F65A017;
  lcb_unit lcb_unit_inst (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .NATIVE_NUMERIC_ERROR_BIT(ne), .ERROR_SUMMARY_FLAG(es),
    .FPU_ERROR_INTERRUPT(irq), .IGNORE_NUMERIC_FAULT(ign), .IO_REQ(io_req), .SMI_REQ(smi),
    .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .PCI_INTERNAL_ACCESS_ENABLE(pci), .DRAM_TOP(dram_top));
  lcb_far_side lcb_far_side_inst (.ref_clk(ref_clk), .smi_req(smi), .mem_rsp(mem_rsp),
    .io_req(io_req), .mem_req(mem_req), .ne(ne), .es(es));
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask
  // Expected attribute flags {legacy, read, write, cache, pci, graphics}
  function automatic logic [31:0] ex(input logic l, input logic [3:0] f, input logic g);
    return {26'h0, l, f[RC_READ], f[RC_WRITE], f[RC_CACHE] && !g, f[RC_PCI], g};
  endfunction
  function automatic logic [31:0] fl(input lcb_mem_rsp_t x);
    return {26'h0, x.legacy, x.rd_en, x.wr_en, x.cache_en, x.pci_en, x.to_gfx};
  endfunction
  ////////////////////////////////////////
  initial begin
    logic [31:0] v;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, n_checks} = '0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(OFF_DRAM_TOP, 32'h3FFFFFFF, 1'b0);
    rd_chk(OFF_XMAP_AB, 32'h0, 1'b0);
    rd_chk(OFF_XMAP_CD, 32'h0, 1'b0);
    rd_chk(OFF_XMAP_EF, 32'h0, 1'b0);
    wr(16'h8010, 32'hFFFFFFFF);
    rd_chk(16'h8010, 32'h0, 1'b0);
    rd_chk(16'h8100, 32'h0, 1'b1);
    rd_chk(16'h8002, 32'h0, 1'b1);
    wr(OFF_DRAM_TOP, 32'h0);
    rd_chk(OFF_DRAM_TOP, 32'h0001FFFF, 1'b0);
    wr(OFF_DRAM_TOP, 32'h0FFE0000);
    repeat (2) @(posedge ref_clk);
    chk(dram_top, 32'h0FFFFFFF);
    for (int i = 0; i < 3; i++) begin
      lcb_far_side_inst.io(16'h03B4 + 16'(i * 16), 1'b0, s);
      chk({31'h0, s}, 32'h0);
    end
    wr(OFF_XMAP_AB, MAP_AB);
    rd_chk(OFF_XMAP_AB, MAP_AB, 1'b0);
    chk({31'h0, pci}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lcb_far_side_inst.io(16'h03B4 + 16'(i * 16), 1'b0, s);
      chk({31'h0, s}, {31'h0, i == 0 || i == 2});
    end
    wr(OFF_XMAP_CD, 32'hFEDCBA98);
    wr(OFF_XMAP_EF, 32'h76543210);
    for (int k = 0; k < 16; k++) begin
      v = (k < 8 ? 32'hFEDCBA98 : 32'h76543210) >> (4 * (k % 8));
      lcb_far_side_inst.mem(32'h000C0000 + 32'(k) * 32'h4000, 1'b0, r);
      chk(fl(r), ex(1'b1, v[3:0], 1'b0));
    end
    lcb_far_side_inst.mem(32'h000A0000, 1'b0, r);
    chk(fl(r), ex(1'b1, 4'h7, 1'b1));
    lcb_far_side_inst.mem(32'h000B0000, 1'b0, r);
    chk(fl(r), ex(1'b1, 4'h5, 1'b0));
    lcb_far_side_inst.mem(32'h000B8000, 1'b0, r);
    chk(fl(r), ex(1'b1, 4'hF, 1'b1));
    lcb_far_side_inst.mem(32'h001A0000, 1'b0, r);
    chk(r.addr, 32'h000A0000);
    lcb_far_side_inst.mem(32'h001A0000, 1'b1, r);
    chk({r.addr, r.legacy}, {32'h001A0000, 1'b0});
    lcb_far_side_inst.mem(32'h10000000, 1'b0, r);
    chk({31'h0, r.above_top}, 32'h1);
    lcb_far_side_inst.mem(32'h0FFFFFFF, 1'b0, r);
    chk({31'h0, r.above_top}, 32'h0);
    wr(OFF_XMAP_AB, 32'h0);
    lcb_far_side_inst.mem(32'h001A0000, 1'b0, r);
    chk(r.addr, 32'h001A0000);
    lcb_far_side_inst.fpu(1'b1, 1'b1);
    chk({31'h0, irq}, 32'h0);
    lcb_far_side_inst.fpu(1'b0, 1'b0);
    lcb_far_side_inst.fpu(1'b0, 1'b1);
    chk({31'h0, irq}, 32'h1);
    lcb_far_side_inst.io(IO_FPU_ACK1, 1'b1, s);
    chk({30'h0, irq, ign}, 32'h1);
    lcb_far_side_inst.fpu(1'b0, 1'b0);
    chk({30'h0, irq, ign}, 32'h0);
    lcb_far_side_inst.fpu(1'b0, 1'b1);
    chk({31'h0, irq}, 32'h1);
    lcb_far_side_inst.io(IO_FPU_ACK0, 1'b1, s);
    chk({30'h0, irq, ign}, 32'h1);
    wrap_up();
  end
endmodule
